/* File: hdl/ipm_ctrl.sv */
`timescale 1ns/1ns
module ipm_ctrl
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  // vector priority writes, field x for slot x
  input  wire logic [4:0]           spr_wr,
  input  wire logic [9:0]           spr_wdata,
  output logic      [9:0]           spr_rdata,
  // global configuration
  input  wire logic                 return_to_sleep_wr,
  input  wire logic                 return_to_sleep_wdata,
  output logic                      return_to_sleep_bit,
  // core instruction events and service handshake
  input  wire ipm_pkg::ipm_instr_s  instr,
  input  wire logic                 trap_req,
  input  wire logic                 nmi_req,
  input  wire logic                 reset_req,
  input  wire logic                 svc_ack,
  output logic                      svc_req,
  output ipm_pkg::ipm_src_e         svc_src,
  output logic                      save_context,
  output logic                      return_to_wait,
  output logic      [1:0]           cur_level,
  output logic                      nested_mode,
  // maskable peripheral requests on slots zero..four
  input  wire logic [4:0]           vec_req,
  // which slot serves each port group
  input  wire logic [2:0]           port_slot [4],
  // detector events per port line, from capture logic
  input  wire logic [5:0]           line_event [4],
  input  wire logic [3:0]           cmp_out,
  input  wire logic                 port3_present,
  input  wire logic                 port1_present,
  // port masks and flags
  input  wire logic [5:0]           port0_line_enables,
  input  wire logic [5:0]           port1_line_enables,
  input  wire logic [3:0]           comparator_line_mask,
  input  wire logic                 aux_wr,
  input  wire logic                 port0_global_mask_wdata,
  input  wire logic [5:0]           port2_line_masks_wdata,
  input  wire logic                 pullup_wr,
  input  wire logic [5:0]           pullup_wdata,
  input  wire logic [3:0]           flag_wr,
  input  wire logic [5:0]           flag_wdata,
  output logic                      port0_global_mask,
  output logic      [5:0]           port2_line_masks,
  output logic      [5:0]           pullup_enable,
  output logic      [5:0]           port_flag [4],
  output logic      [3:0]           port_irq
);

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic rst_s1;
  logic rst_n;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // rank of a level code, higher rank wins
  function automatic logic [1:0] rank(input logic [1:0] code);
    case (code)
      ipm_pkg::LVL0: rank = 2'h0;
      ipm_pkg::LVL1: rank = 2'h1;
      ipm_pkg::LVL2: rank = 2'h2;
      default:       rank = 2'h3;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // vector priority fields
  // ------------------------------------------------------------------
  logic [1:0] spr [5];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < ipm_pkg::NUM_VEC; i++)
        spr[i] <= ipm_pkg::SPR_RST;
    else
      for (int i = 0; i < ipm_pkg::NUM_VEC; i++)
        if (spr_wr[i] && spr_wdata[2*i +: 2] != ipm_pkg::LVL0)
          spr[i] <= spr_wdata[2*i +: 2];
  end

  always_comb
  begin
    nested_mode = 1'b0;
    for (int i = 0; i < ipm_pkg::NUM_VEC; i++)
    begin
      spr_rdata[2*i +: 2] = spr[i];
      if (spr[i] != ipm_pkg::LVL3)
        nested_mode = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // port detectors, masks and flags
  // ------------------------------------------------------------------
  logic [5:0] line_en [4];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port0_global_mask <= ipm_pkg::P0GMASK_RST;
      port2_line_masks  <= ipm_pkg::P2MASK_RST;
    end
    else if (aux_wr)
    begin
      port0_global_mask <= port0_global_mask_wdata;
      port2_line_masks  <= port2_line_masks_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pullup_enable <= ipm_pkg::PULLUP_RST;
    else if (pullup_wr)
      pullup_enable <= pullup_wdata;
  end

  always_comb
  begin
    line_en[0] = port0_global_mask ? port0_line_enables : 6'h3f;
    line_en[1] = port1_present ? port1_line_enables
                               : ipm_pkg::LINES_ZERO;
    line_en[2] = ~port2_line_masks;
    line_en[3] = port3_present ? {2'h0, ~comparator_line_mask}
                               : ipm_pkg::LINES_ZERO;
  end

  // flags record every sensed event; polling sees them even when masked
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      for (int p = 0; p < ipm_pkg::NUM_PORT; p++)
        port_flag[p] <= ipm_pkg::LINES_ZERO;
    else
    begin
      for (int p = 0; p < 3; p++)
        // set beats a same-cycle clear
        port_flag[p] <= (port_flag[p]
                        & ~(flag_wr[p] ? flag_wdata : 6'h00))
                        | line_event[p];
      // comparator outputs go straight into detection
      port_flag[3] <= (port_flag[3] & ~(flag_wr[3] ? flag_wdata : 6'h00))
                      | {2'h0, port3_present ? cmp_out : 4'h0};
    end
  end

  always_comb
    for (int p = 0; p < ipm_pkg::NUM_PORT; p++)
      port_irq[p] = |(port_flag[p] & line_en[p]);

  // ------------------------------------------------------------------
  // arbitration
  // ------------------------------------------------------------------
  logic [4:0]  pend;
  logic [1:0]  best_rank;
  logic [2:0]  best_vec;
  logic        best_ok;
  logic        in_isr;
  logic [2:0]  isr_vec;

  always_comb
  begin
    pend = vec_req;
    for (int p = 0; p < ipm_pkg::NUM_PORT; p++)
      if (port_irq[p] && port_slot[p] < 3'(ipm_pkg::NUM_VEC))
        pend[port_slot[p]] = 1'b1;
  end

  always_comb
  begin
    best_ok   = 1'b0;
    best_rank = 2'h0;
    best_vec  = 3'h0;
    // slot zero has the highest hardware priority, so scan downward
    for (int i = ipm_pkg::NUM_VEC - 1; i >= 0; i--)
      if (pend[i] && (!best_ok || rank(spr[i]) >= best_rank))
      begin
        best_ok   = 1'b1;
        best_rank = rank(spr[i]);
        best_vec  = 3'(i);
      end
  end

  logic              take_vec;
  logic              reentry;
  ipm_pkg::ipm_src_e next_src;

  // a raised level of the own pending vector beats the current one
  assign reentry  = in_isr && pend[isr_vec] && best_vec == isr_vec
                    && rank(spr[isr_vec]) > rank(cur_level);
  assign take_vec = best_ok && (best_rank > rank(cur_level) || reentry);

  always_comb
  begin
    if (reset_req)
      next_src = ipm_pkg::IPM_SRC_RESET;
    else if (nmi_req)
      next_src = ipm_pkg::IPM_SRC_NMI;
    else if (trap_req)
      next_src = ipm_pkg::IPM_SRC_TRAP;
    else if (take_vec)
      next_src = ipm_pkg::ipm_src_e'(4'(best_vec) + 4'h1);
    else
      next_src = ipm_pkg::IPM_SRC_NONE;
  end

  assign svc_req = next_src != ipm_pkg::IPM_SRC_NONE;
  assign svc_src = next_src;

  // ------------------------------------------------------------------
  // current level, service state and return-to-wait
  // ------------------------------------------------------------------
  logic [1:0] main_level;
  logic       sleeping_loop;
  logic       loop_saved;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      return_to_sleep_bit <= 1'b0;
    else if (return_to_sleep_wr)
      return_to_sleep_bit <= return_to_sleep_wdata;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_level     <= ipm_pkg::LVL3;
      main_level    <= ipm_pkg::LVL3;
      in_isr        <= 1'b0;
      isr_vec       <= 3'h0;
      sleeping_loop <= 1'b0;
    end
    else if (svc_req && svc_ack)
    begin
      in_isr  <= 1'b1;
      isr_vec <= best_vec;
      if (svc_src inside {ipm_pkg::IPM_SRC_RESET, ipm_pkg::IPM_SRC_NMI,
                          ipm_pkg::IPM_SRC_TRAP})
        cur_level <= ipm_pkg::LVL3;
      else
        cur_level <= nested_mode ? spr[best_vec] : ipm_pkg::LVL3;
      if (!in_isr)
        main_level <= cur_level;
    end
    else if (instr.interrupt_return_instr)
    begin
      in_isr <= 1'b0;
      // stay in the wait loop only while the bit is set
      sleeping_loop <= sleeping_loop && return_to_sleep_bit;
      cur_level     <= main_level;
    end
    else if (instr.wait_for_interrupt_instr)
    begin
      cur_level <= ipm_pkg::LVL0;
      if (!in_isr && return_to_sleep_bit)
        sleeping_loop <= 1'b1;
    end
    else if (instr.halt || instr.enable_interrupts_instr)
      cur_level <= ipm_pkg::LVL0;
    else if (instr.sim)
      cur_level <= ipm_pkg::LVL3;
    else if (instr.pop_condition_code_instr)
      cur_level <= instr.pop_condition_code_instr_lvl;
  end

  // first wake-up of a wait loop stacks the context, later ones reuse it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      loop_saved <= 1'b0;
    else if (!sleeping_loop)
      loop_saved <= 1'b0;
    else if (save_context)
      loop_saved <= 1'b1;
  end

  assign save_context   = svc_req && svc_ack && !in_isr
                          && !(sleeping_loop && loop_saved);
  assign return_to_wait = instr.interrupt_return_instr && sleeping_loop
                          && return_to_sleep_bit;

endmodule

/* File: hdl/ipm_pkg.sv */
package ipm_pkg;

  // ------------------------------------------------------------------
  // sizes and counts
  // ------------------------------------------------------------------
  localparam int NUM_VEC   = 5;   // maskable vector slots zero..four
  localparam int NUM_PORT  = 4;   // port groups 0..3
  localparam int LINES     = 6;   // lines per port group
  localparam int CMP_LINES = 4;   // comparator lines on port 3

  // ------------------------------------------------------------------
  // two-bit priority codes, same meaning as the core level bits
  // ------------------------------------------------------------------
  localparam logic [1:0] LVL0 = 2'h2;  // lowest
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] LVL2 = 2'h0;  // highest interruptible
  localparam logic [1:0] LVL3 = 2'h3;  // non-interruptible

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [1:0] SPR_RST     = 2'h3;
  localparam logic [5:0] PULLUP_RST  = 6'h3f;
  localparam logic [5:0] P2MASK_RST  = 6'h00;
  localparam logic       P0GMASK_RST = 1'b0;
  localparam logic [5:0] LINES_ZERO  = 6'h00;

  // ------------------------------------------------------------------
  // service selection codes
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    IPM_SRC_NONE,
    IPM_SRC_VEC0,
    IPM_SRC_VEC1,
    IPM_SRC_VEC2,
    IPM_SRC_VEC3,
    IPM_SRC_VEC4,
    IPM_SRC_TRAP,
    IPM_SRC_NMI,
    IPM_SRC_RESET
  } ipm_src_e;

  // core instruction events, one-cycle pulses
  typedef struct packed {
    logic       wait_for_interrupt_instr;       // wait_for_interrupt_instr
    logic       interrupt_return_instr;      // interrupt_return_instr
    logic       pop_condition_code_instr;     // pop_condition_code_instr
    logic       enable_interrupts_instr;       // enable_interrupts_instr
    logic       sim;       // disable_interrupts_instr
    logic       halt;
    logic [1:0] pop_condition_code_instr_lvl; // level bits popped with the condition code
  } ipm_instr_s;

endpackage

/* File: test/ipm_ctrl_asserts.sv */
`timescale 1ns/1ns
module ipm_ctrl_asserts
(
  // clock and reset
  input wire logic                core_clk,
  input wire logic                arst_n,
  // priority fields
  input wire logic [4:0]          spr_wr,
  input wire logic [9:0]          spr_wdata,
  input wire logic [9:0]          spr_rdata,
  input wire logic                nested_mode,
  // core side
  input wire ipm_pkg::ipm_instr_s instr,
  input wire logic                return_to_sleep_bit,
  input wire logic                return_to_wait,
  input wire logic                svc_ack,
  input wire logic                svc_req,
  input wire ipm_pkg::ipm_src_e   svc_src,
  input wire logic [1:0]          cur_level,
  input wire logic                nmi_req,
  input wire logic                reset_req,
  // port flags
  input wire logic [5:0]          line_event [4],
  input wire logic [3:0]          flag_wr,
  input wire logic [5:0]          flag_wdata,
  input wire logic [5:0]          port_flag [4],
  input wire logic [5:0]          port2_line_masks,
  input wire logic [3:0]          port_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  chk_spr_keep: assert property (
    spr_wr[0] && spr_wdata[1:0] == 2'h2 |=> $stable(spr_rdata[1:0]))
    else $error("slot zero field changed on ignored code");
  chk_spr_store: assert property (
    spr_wr[0] && spr_wdata[1:0] != 2'h2
    |=> spr_rdata[1:0] == $past(spr_wdata[1:0]))
    else $error("slot zero field not stored");
  chk_nested_mode: assert property (
    nested_mode == (spr_rdata != 10'h3ff))
    else $error("nested mode disagrees with priority fields");
  chk_port2_irq: assert property (
    port_irq[2] == |(port_flag[2] & ~port2_line_masks))
    else $error("port two request ignores its masks");
  chk_flag_clear: assert property (
    flag_wr[2] && line_event[2] == 6'h00
    |=> (port_flag[2] & $past(flag_wdata)) == 6'h00)
    else $error("written flag not cleared");
  chk_trap_level: assert property (
    svc_ack && svc_src == ipm_pkg::IPM_SRC_TRAP |=> cur_level == 2'h3)
    else $error("trap entry left level bits open");
  chk_nmi_first: assert property (
    $rose(nmi_req) && !reset_req
    |-> svc_req && svc_src == ipm_pkg::IPM_SRC_NMI)
    else $error("nmi not chosen over lower sources");
  chk_no_wait: assert property (
    instr.interrupt_return_instr && !return_to_sleep_bit |-> !return_to_wait)
    else $error("return went to wait with bit clear");
  // ------------------------------------------------------------------
  // coverage
  // ------------------------------------------------------------------
  cov_vec2: cover property (svc_ack && svc_src == ipm_pkg::IPM_SRC_VEC2);
  cov_wait: cover property (instr.interrupt_return_instr && return_to_wait);
  cov_clear: cover property (flag_wr[2] && port_flag[2] != 6'h00);
endmodule
bind ipm_ctrl ipm_ctrl_asserts u_chk (.*);

/* File: test/ipm_core_model.sv */
`timescale 1ns/1ns
module ipm_core_model
(
  // clock
  input  wire logic core_clk,
  // service handshake
  input  wire logic svc_req,
  input  wire logic auto_ack,
  output logic      svc_ack
);
  // a gap after each ack keeps a held level request from being taken twice
  initial svc_ack = 1'b0;
  always @(posedge core_clk)
    svc_ack <= #1 auto_ack && svc_req && !svc_ack;
endmodule

/* File: test/test_interrupt_priority_and_port_masking.sv */
`timescale 1ns/1ns
module test_interrupt_priority_and_port_masking;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  localparam int D = 2;
  logic               core_clk = 1'b0, arst_n = 1'b0, auto_ack = 1'b1;
  logic [4:0]         spr_wr = 5'h00, vec_req = 5'h00;
  logic [9:0]         spr_wdata = 10'h000, spr_rdata;
  logic               return_to_sleep_wr = 1'b0, return_to_sleep_wdata = 1'b0;
  ipm_pkg::ipm_instr_s instr = '0;
  logic               trap_req = 1'b0, nmi_req = 1'b0, reset_req = 1'b0;
  logic [2:0]         port_slot [4] = '{default: 3'h7};
  logic [5:0]         line_event [4] = '{default: 6'h00};
  logic [3:0]         cmp_out = 4'h0, comparator_line_mask = 4'hf;
  logic               port3_present = 1'b0, port1_present = 1'b1;
  logic [5:0]         port0_line_enables = 6'h00, port1_line_enables = 6'h00;
  logic               aux_wr = 1'b0, port0_global_mask_wdata = 1'b0;
  logic [5:0]         port2_line_masks_wdata = 6'h00, pullup_wdata = 6'h00;
  logic               pullup_wr = 1'b0;
  logic [3:0]         flag_wr = 4'h0, port_irq;
  logic [5:0]         flag_wdata = 6'h00, port2_line_masks, pullup_enable;
  logic [5:0]         port_flag [4];
  logic               return_to_sleep_bit, svc_ack, svc_req, save_context;
  logic               return_to_wait, nested_mode, port0_global_mask;
  logic [1:0]         cur_level;
  ipm_pkg::ipm_src_e  svc_src;
  int                 n_fail = 0, compares = 0;

  ipm_ctrl DUT (.*);
  ipm_core_model u_core (.core_clk(core_clk), .svc_req(svc_req),
                         .auto_ack(auto_ack), .svc_ack(svc_ack));
  always #25 core_clk = ~core_clk;
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #D;
  endtask
  task spw(input logic [4:0] m, input logic [9:0] d);
    spr_wr = m;
    spr_wdata = d;
    step(1);
    spr_wr = 5'h00;
    step(1);
  endtask
  // bits wfi, interrupt_return_instr, pop_condition_code_instr, rim, sim, halt
  task ins(input logic [5:0] b);
    instr = ipm_pkg::ipm_instr_s'({b, 2'h0});
    step(1);
    instr = '0;
    step(1);
  endtask
  task ret(input logic w);
    instr.interrupt_return_instr = 1'b1;
    #1 chk(return_to_wait, w);
    step(1);
    instr = '0;
    step(1);
  endtask
  task sleep_bit(input logic v);
    return_to_sleep_wr = 1'b1;
    return_to_sleep_wdata = v;
    step(1);
    return_to_sleep_wr = 1'b0;
    step(1);
  endtask
  // waits for the core's ack, then judges source, stacking and level
  task take(input ipm_pkg::ipm_src_e s, input int sv, input logic [1:0] l);
    int n;
    n = 0;
    while (svc_ack !== 1'b1 && n < 20)
    begin
      step(1);
      n++;
    end
    chk(svc_ack, 1'b1);
    chk(svc_src, s);
    if (sv >= 0)
      chk(save_context, sv[0]);
    step(1);
    chk(cur_level, l);
  endtask
  task ev(input int p, input logic [5:0] v);
    line_event[p] = v;
    step(1);
    line_event[p] = 6'h00;
    step(1);
  endtask
  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task test_reset;
    chk(cur_level, 2'h3);
    chk(spr_rdata, 10'h3ff);
    chk(pullup_enable, 6'h3f);
    chk({port0_global_mask, port2_line_masks}, 7'h00);
    $display("test_reset done");
  endtask
  task test_spr;
    spw(5'h1f, 10'h155);
    chk(nested_mode, 1'b1);
    spw(5'h1f, 10'h2aa);
    chk(spr_rdata, 10'h155);
    spw(5'h04, 10'h000);
    chk(spr_rdata, 10'h145);
    $display("test_spr done");
  endtask
  task test_sleep;
    sleep_bit(1'b1);
    chk(return_to_sleep_bit, 1'b1);
    ins(6'h04);
    ins(6'h20);
    vec_req = 5'h07;
    take(ipm_pkg::IPM_SRC_VEC2, 1, 2'h0);
    vec_req = 5'h03;
    step(1);
    chk(svc_req, 1'b0);
    ret(1'b1);
    take(ipm_pkg::IPM_SRC_VEC0, 0, 2'h1);
    vec_req = 5'h00;
    sleep_bit(1'b0);
    ret(1'b0);
    chk(cur_level, 2'h2);
    $display("test_sleep done");
  endtask
  task test_reenter;
    vec_req = 5'h02;
    take(ipm_pkg::IPM_SRC_VEC1, 1, 2'h1);
    spw(5'h02, 10'h000);
    take(ipm_pkg::IPM_SRC_VEC1, 0, 2'h0);
    vec_req = 5'h00;
    ins(6'h02);
    chk(cur_level, 2'h3);
    ins(6'h01);
    chk(cur_level, 2'h2);
    ret(1'b0);
    chk(cur_level, 2'h2);
    $display("test_reenter done");
  endtask
  task test_conc;
    spw(5'h1f, 10'h3ff);
    chk(nested_mode, 1'b0);
    vec_req = 5'h10;
    take(ipm_pkg::IPM_SRC_VEC4, 1, 2'h3);
    vec_req = 5'h01;
    step(1);
    chk(svc_req, 1'b0);
    vec_req = 5'h00;
    auto_ack = 1'b0;
    trap_req = 1'b1;
    step(1);
    chk(svc_src, ipm_pkg::IPM_SRC_TRAP);
    nmi_req = 1'b1;
    step(1);
    chk(svc_src, ipm_pkg::IPM_SRC_NMI);
    reset_req = 1'b1;
    step(1);
    chk(svc_src, ipm_pkg::IPM_SRC_RESET);
    reset_req = 1'b0;
    nmi_req = 1'b0;
    auto_ack = 1'b1;
    take(ipm_pkg::IPM_SRC_TRAP, -1, 2'h3);
    trap_req = 1'b0;
    ret(1'b0);
    ret(1'b0);
    $display("test_conc done");
  endtask
  task test_ports;
    ev(2, 6'h01);
    chk(port_flag[2], 6'h01);
    chk(port_irq, 4'h4);
    aux_wr = 1'b1;
    port2_line_masks_wdata = 6'h01;
    step(1);
    chk(port_irq[2], 1'b0);
    flag_wr = 4'h4;
    flag_wdata = 6'h01;
    ev(0, 6'h02);
    flag_wr = 4'h0;
    chk(port_flag[2], 6'h00);
    chk(port_irq[0], 1'b1);
    port0_global_mask_wdata = 1'b1;
    step(1);
    aux_wr = 1'b0;
    chk(port_irq[0], 1'b0);
    port0_line_enables = 6'h02;
    port1_line_enables = 6'h04;
    ev(1, 6'h04);
    chk(port_irq[1:0], 2'h3);
    pullup_wr = 1'b1;
    pullup_wdata = 6'h15;
    step(1);
    pullup_wr = 1'b0;
    chk(pullup_enable, 6'h15);
    port3_present = 1'b1;
    comparator_line_mask = 4'he;
    cmp_out = 4'h3;
    step(1);
    cmp_out = 4'h0;
    chk(port_flag[3], 6'h03);
    chk(port_irq[3], 1'b1);
    comparator_line_mask = 4'hf;
    step(1);
    chk(port_irq[3], 1'b0);
    port_slot[0] = 3'h3;
    take(ipm_pkg::IPM_SRC_VEC3, 1, 2'h3);
    port_slot[0] = 3'h7;
    ret(1'b0);
    $display("test_ports done");
  endtask
  // ------------------------------------------------------------------
  // run control
  // ------------------------------------------------------------------
  task stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    step(3);
    arst_n = 1'b1;
    step(3);
    test_reset;
    test_spr;
    test_sleep;
    test_reenter;
    test_conc;
    test_ports;
    stop_test;
  end
  // the scenarios need under a hundred cycles; this allows some thousands
  initial
  begin
    #200000;
    n_fail++;
    stop_test;
  end
endmodule
